// [verilog/handler_io_consts.svh]
`ifndef HANDLER_IO_CONSTS_SVH
`define HANDLER_IO_CONSTS_SVH
// Register byte offsets
`define OFS_BYTE_A 8'h00
`define OFS_BYTE_B 8'h04
`define OFS_NIB_C 8'h08
`define OFS_NIB_D 8'h0c
`define OFS_DIR 8'h10
`define OFS_RESULT 8'h14
`define OFS_SWEEP 8'h18
`define OFS_STATUS 8'h1c
`define OFS_AUX 8'h20
// Field positions
`define DIR_C_BIT 0
`define DIR_D_BIT 1
`define RES_PASS_BIT 0
`define RES_POL_BIT 1
`define ST_STROBE_BIT 0
`define ST_PF_BIT 1
`define ST_SWEEP_BIT 2
`define ST_POWER_BIT 3
// Times in ns and derived cycle counts at 100 MHz
`define CLK_PERIOD_NS 10
`define STROBE_MIN_NS 1000
`define TRIG_MIN_NS 1000
`define SWEEP_MIN_NS 10000
`define STROBE_CYC ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIG_CYC ((`TRIG_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWEEP_CYC ((`SWEEP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 14
`endif

// [verilog/handler_io_pkg.sv]
`default_nettype none
package handler_io_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_LOW = 2'b10
	} strobe_state_t;
	typedef struct packed {
		logic [7:0] byte_a;
		logic [7:0] byte_b;
		logic [3:0] nib_c;
		logic [3:0] nib_d;
	} port_data_t;
	typedef struct packed {
		logic dir_c;
		logic dir_d;
	} port_dir_t;
endpackage
`default_nettype wire

// [verilog/low_pulse_gen.sv]
`include "handler_io_consts.svh"
`default_nettype none
// Active-low pulse: one setup cycle with the line high, then LEN low cycles.
// The setup cycle gives data one full cycle to settle before the fall.
module low_pulse_gen import handler_io_pkg::*; #(
	parameter logic [`CNT_W-1:0] LEN = 14'h0001
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Sync reset
	input wire logic start_i, // Start request
	output logic busy_o, // Pulse in progress
	output logic pulse_n_o // Active-low pulse
);
	strobe_state_t state_q;
	logic [`CNT_W-1:0] cnt_q;

	// Sequencer; starts during a pulse are ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: if (start_i) begin
					state_q <= ST_SETUP;
				end
				ST_SETUP: begin
					state_q <= ST_LOW;
					cnt_q <= LEN - 14'h0001;
				end
				ST_LOW: if (cnt_q == '0) begin
					state_q <= ST_IDLE;
				end else begin
					cnt_q <= cnt_q - 14'h0001;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Registered low output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_n_o <= 1'b1;
		end else begin
			pulse_n_o <= !(state_q == ST_SETUP ||
				(state_q == ST_LOW && cnt_q != '0));
		end
	end

	assign busy_o = (state_q != ST_IDLE) || !pulse_n_o;

	a_pulse_width: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(pulse_n_o) |-> !pulse_n_o [*8])
		else $error("pulse shorter than minimum");
endmodule
`default_nettype wire

// [verilog/handler_parallel_io_port.sv]
// Behaviour
// - Low trigger pulse loads both aux outputs
// - Status line high when bidirectional port outputs
// - Port writes give active-low strobe, 1 us
// - Held pass/fail output, selectable pass polarity
// - Sweep done drives low at least 10 us
// - Result update gives pass/fail strobe, 1 us
// - Low power input acts as power key
// - Two 8-bit output ports hold last value
// - Two 4-bit bidirectional ports hold written value
`include "handler_io_consts.svh"
`default_nettype none
module handler_parallel_io_port import handler_io_pkg::*; (
	input wire logic clk_i, // 100 MHz clock
	input wire logic rst_i, // Sync reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic aux_load_trigger_in_i, // Active-low trigger
	input wire logic [1:0] aux_src_i, // Values for aux outputs
	output logic [1:0] aux_held_outputs_o, // Latched aux outputs
	output logic [7:0] first_byte_out_port_o, // Byte port A
	output logic [7:0] second_byte_out_port_o, // Byte port B
	input wire logic [3:0] nib_c_i, // Port C pin levels
	output logic [3:0] nib_c_o, // Port C drive value
	output logic [3:0] nib_c_oe_o, // Port C enable
	input wire logic [3:0] nib_d_i, // Port D pin levels
	output logic [3:0] nib_d_o, // Port D drive value
	output logic [3:0] nib_d_oe_o, // Port D enable
	output logic dir_c_o, // Port C status, high=output
	output logic dir_d_o, // Port D status, high=output
	output logic data_strobe_n_o, // Data write strobe
	output logic pass_fail_o, // Held result level
	output logic pf_strobe_n_o, // Pass/fail write strobe
	output logic sweep_done_n_o, // Sweep-done pulse
	input wire logic power_remote_n_i, // Open-collector power input
	output logic power_key_o // Power key press event
);
	port_data_t data_q;
	port_dir_t dir_q;
	logic pass_q, pol_q;
	logic [`CNT_W-1:0] trig_cnt_q;
	logic trig_armed_q;
	logic pwr_q;
	logic data_busy, pf_busy, sweep_busy;
	logic wr, rd, data_wr, pf_wr, sweep_wr;

	// Single-cycle Wishbone: ack one cycle after request, then drop
	assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
	assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
	assign data_wr = wr && wb_sel_i[0] && !data_busy &&
		(wb_adr_i == `OFS_BYTE_A || wb_adr_i == `OFS_BYTE_B ||
		wb_adr_i == `OFS_NIB_C || wb_adr_i == `OFS_NIB_D ||
		wb_adr_i == `OFS_DIR);
	assign pf_wr = wr && wb_sel_i[0] && !pf_busy &&
		wb_adr_i == `OFS_RESULT;
	assign sweep_wr = wr && wb_sel_i[0] && wb_dat_i[0] &&
		wb_adr_i == `OFS_SWEEP;

	// Ack generation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Port data; a write during a running strobe is dropped, so the
	// pins never change while the strobe is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_q <= '0;
			dir_q <= '0;
		end else if (data_wr) begin
			case (wb_adr_i)
				`OFS_BYTE_A: data_q.byte_a <= wb_dat_i[7:0];
				`OFS_BYTE_B: data_q.byte_b <= wb_dat_i[7:0];
				`OFS_NIB_C: data_q.nib_c <= wb_dat_i[3:0];
				`OFS_NIB_D: data_q.nib_d <= wb_dat_i[3:0];
				`OFS_DIR: begin
					dir_q.dir_c <= wb_dat_i[`DIR_C_BIT];
					dir_q.dir_d <= wb_dat_i[`DIR_D_BIT];
				end
				default: data_q <= data_q;
			endcase
		end
	end

	// Result bit and polarity; pass drives the level chosen by polarity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pass_q <= 1'b0;
			pol_q <= 1'b1;
		end else if (pf_wr) begin
			pass_q <= wb_dat_i[`RES_PASS_BIT];
			pol_q <= wb_dat_i[`RES_POL_BIT];
		end
	end

	// Pin drives from registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			first_byte_out_port_o <= '0;
			second_byte_out_port_o <= '0;
			nib_c_o <= '0;
			nib_d_o <= '0;
			nib_c_oe_o <= '0;
			nib_d_oe_o <= '0;
			dir_c_o <= 1'b0;
			dir_d_o <= 1'b0;
			pass_fail_o <= 1'b0;
		end else begin
			first_byte_out_port_o <= data_q.byte_a;
			second_byte_out_port_o <= data_q.byte_b;
			nib_c_o <= data_q.nib_c;
			nib_d_o <= data_q.nib_d;
			nib_c_oe_o <= {4{dir_q.dir_c}};
			nib_d_oe_o <= {4{dir_q.dir_d}};
			dir_c_o <= dir_q.dir_c;
			dir_d_o <= dir_q.dir_d;
			pass_fail_o <= pass_q ~^ pol_q;
		end
	end

	// Strobes start a cycle after the register load; the setup cycle
	// inside the pulse generator lets the pins settle first
	logic data_go_q, pf_go_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_go_q <= 1'b0;
			pf_go_q <= 1'b0;
		end else begin
			data_go_q <= data_wr;
			pf_go_q <= pf_wr;
		end
	end

	low_pulse_gen #(.LEN(`CNT_W'(`STROBE_CYC))) u_data_strobe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(data_go_q),
		.busy_o(data_busy),
		.pulse_n_o(data_strobe_n_o)
	);

	low_pulse_gen #(.LEN(`CNT_W'(`STROBE_CYC))) u_pf_strobe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(pf_go_q),
		.busy_o(pf_busy),
		.pulse_n_o(pf_strobe_n_o)
	);

	// Sweep done is written by software when a sweep completes
	low_pulse_gen #(.LEN(`CNT_W'(`SWEEP_CYC))) u_sweep_done (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(sweep_wr),
		.busy_o(sweep_busy),
		.pulse_n_o(sweep_done_n_o)
	);

	// Trigger qualifier: low must persist 1 us before aux loads once;
	// shorter glitches are ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_cnt_q <= '0;
			trig_armed_q <= 1'b1;
			aux_held_outputs_o <= '0;
		end else if (aux_load_trigger_in_i) begin
			trig_cnt_q <= '0;
			trig_armed_q <= 1'b1;
		end else if (trig_armed_q) begin
			if (trig_cnt_q == `CNT_W'(`TRIG_CYC - 1)) begin
				aux_held_outputs_o <= aux_src_i;
				trig_armed_q <= 1'b0;
			end else begin
				trig_cnt_q <= trig_cnt_q + 14'h0001;
			end
		end
	end

	// Power key: one-cycle press event on falling level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q <= 1'b1;
			power_key_o <= 1'b0;
		end else begin
			pwr_q <= power_remote_n_i;
			power_key_o <= pwr_q && !power_remote_n_i;
		end
	end

	// Read mux; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (rd) begin
			case (wb_adr_i)
				`OFS_BYTE_A: wb_dat_o <= {24'h000000, data_q.byte_a};
				`OFS_BYTE_B: wb_dat_o <= {24'h000000, data_q.byte_b};
				`OFS_NIB_C: wb_dat_o <= {28'h0000000,
					dir_q.dir_c ? data_q.nib_c : nib_c_i};
				`OFS_NIB_D: wb_dat_o <= {28'h0000000,
					dir_q.dir_d ? data_q.nib_d : nib_d_i};
				`OFS_DIR: wb_dat_o <= {30'h0, dir_q.dir_d,
					dir_q.dir_c};
				`OFS_RESULT: wb_dat_o <= {30'h0, pol_q, pass_q};
				`OFS_STATUS: wb_dat_o <= {28'h0000000, !power_remote_n_i,
					sweep_busy, pf_busy, data_busy};
				`OFS_AUX: wb_dat_o <= {30'h0, aux_held_outputs_o};
				default: wb_dat_o <= '0;
			endcase
		end
	end

	// Low-time counter for the sweep-done check; a thousand cycles is
	// too long to unroll as a repetition, so the count is kept here
	logic [`CNT_W-1:0] sweep_low_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sweep_low_q <= '0;
		end else if (!sweep_done_n_o) begin
			sweep_low_q <= sweep_low_q + 14'h0001;
		end else begin
			sweep_low_q <= '0;
		end
	end

	// Checks on pin timing and on register effects
	a_strobe_data: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!data_strobe_n_o |-> $stable(first_byte_out_port_o))
		else $error("port data changed under strobe");
	a_data_stable: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!data_strobe_n_o |-> $stable(second_byte_out_port_o) &&
		$stable(nib_c_o) && $stable(nib_d_o) && $stable(dir_c_o) &&
		$stable(dir_d_o))
		else $error("port pins changed under strobe");
	a_pf_stable: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!pf_strobe_n_o |-> $stable(pass_fail_o))
		else $error("result changed under strobe");
	a_dir_status: assert property (
		@(posedge clk_i) disable iff (rst_i)
		dir_c_o == nib_c_oe_o[0])
		else $error("status line disagrees with direction");
	a_dir_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		data_wr && wb_adr_i == `OFS_DIR |=> ##1
		dir_c_o == $past(wb_dat_i[`DIR_C_BIT], 2) &&
		dir_d_o == $past(wb_dat_i[`DIR_D_BIT], 2))
		else $error("status line does not follow direction write");
	a_sweep_width: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(sweep_done_n_o) |-> sweep_low_q >= `CNT_W'(`SWEEP_CYC))
		else $error("sweep done too short");
	a_sweep_start: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sweep_wr && !sweep_busy |=> ##1 !sweep_done_n_o)
		else $error("sweep done pulse missing");
	a_data_strobe: assert property (
		@(posedge clk_i) disable iff (rst_i)
		data_wr |-> ##3 !data_strobe_n_o [*8])
		else $error("data strobe missing");
	a_pf_strobe: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(pf_strobe_n_o) |-> ##99 !pf_strobe_n_o)
		else $error("pass fail strobe too short");
	a_pf_level: assert property (
		@(posedge clk_i) disable iff (rst_i)
		pf_wr |=> ##1 pass_fail_o == ($past(wb_dat_i[`RES_PASS_BIT], 2) ~^
		$past(wb_dat_i[`RES_POL_BIT], 2)))
		else $error("pass fail level wrong");
	a_power_key: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(power_remote_n_i) |=> power_key_o)
		else $error("power key not seen");
	a_key_single: assert property (
		@(posedge clk_i) disable iff (rst_i)
		power_key_o |=> !power_key_o)
		else $error("power key event longer than one cycle");
	a_aux_load: assert property (
		@(posedge clk_i) disable iff (rst_i)
		trig_armed_q && !aux_load_trigger_in_i &&
		trig_cnt_q == `CNT_W'(`TRIG_CYC - 1)
		|=> aux_held_outputs_o == $past(aux_src_i))
		else $error("aux outputs not loaded");
	a_byte_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!data_wr ##1 !data_wr |=> $stable(second_byte_out_port_o))
		else $error("byte port changed without write");
	a_nib_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!data_wr ##1 !data_wr |=> $stable(nib_c_o))
		else $error("nibble port changed without write");
endmodule
`default_nettype wire

// [verification/handler_fixture.sv]
`default_nettype none
// Parts handler model: trigger pulse, port C/D pins, power input
module handler_fixture (
	input wire logic clk_i, // Clock
	input wire logic go_i, // Start a trigger pulse
	input wire logic [11:0] low_len_i, // Trigger low cycles
	input wire logic [3:0] c_drv_i, // Handler level on C
	input wire logic [3:0] d_drv_i, // Handler level on D
	input wire logic [3:0] c_val_i, // Device drive on C
	input wire logic [3:0] c_oe_i, // Device enable on C
	input wire logic [3:0] d_val_i, // Device drive on D
	input wire logic [3:0] d_oe_i, // Device enable on D
	input wire logic press_i, // Pull the power line down
	output logic trig_n_o, // Trigger line
	output logic [3:0] c_pin_o, // Resolved C pins
	output logic [3:0] d_pin_o, // Resolved D pins
	output logic power_n_o // Power line, pulled up
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] cnt_q = 12'h000;
	// Pulse length is what the bench asks, so short pulses can be tried
	always_ff @(posedge clk_i) begin
		if (go_i) begin
			cnt_q <= low_len_i;
		end else if (cnt_q != 12'h000) begin
			cnt_q <= cnt_q - 12'h001;
		end
	end
	assign trig_n_o = (cnt_q == 12'h000);
	// Device wins a pin only while it enables it
	assign c_pin_o = (c_oe_i & c_val_i) | (~c_oe_i & c_drv_i);
	assign d_pin_o = (d_oe_i & d_val_i) | (~d_oe_i & d_drv_i);
	assign power_n_o = !press_i;
endmodule
`default_nettype wire

// [verification/handler_parallel_io_port_test.sv]
`include "handler_io_consts.svh"
`default_nettype none
module handler_parallel_io_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, go = 0;
	logic press = 0, trig_n, power_n, pkey, dir_c, dir_d, dstb_n, pf;
	logic pfstb_n, swp_n, ok;
	logic [7:0] adr = 8'h00, pa, pb;
	logic [3:0] sel = 4'hf, c_pin, c_val, c_oe, d_pin, d_val, d_oe;
	logic [3:0] c_drv = 4'h6, d_drv = 4'h9;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [11:0] low_len = 12'h000;
	logic [1:0] aux_src = 2'b00, aux_q;
	int n_mismatch = 0, num_checks = 0, w, n;
	always #5 clk_i = ~clk_i;
	handler_parallel_io_port handler_parallel_io_port_inst (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .aux_load_trigger_in_i(trig_n), .aux_src_i(aux_src),
		.aux_held_outputs_o(aux_q), .first_byte_out_port_o(pa),
		.second_byte_out_port_o(pb), .nib_c_i(c_pin), .nib_c_o(c_val),
		.nib_c_oe_o(c_oe), .nib_d_i(d_pin), .nib_d_o(d_val),
		.nib_d_oe_o(d_oe), .dir_c_o(dir_c), .dir_d_o(dir_d),
		.data_strobe_n_o(dstb_n), .pass_fail_o(pf), .pf_strobe_n_o(pfstb_n),
		.sweep_done_n_o(swp_n), .power_remote_n_i(power_n),
		.power_key_o(pkey));
	handler_fixture handler_fixture_inst (.clk_i(clk_i), .go_i(go),
		.low_len_i(low_len), .c_drv_i(c_drv), .d_drv_i(d_drv),
		.c_val_i(c_val), .c_oe_i(c_oe), .d_val_i(d_val), .d_oe_i(d_oe),
		.press_i(press), .trig_n_o(trig_n), .c_pin_o(c_pin),
		.d_pin_o(d_pin), .power_n_o(power_n));
	// Classic single cycle; the wait is cut only by the watchdog
	task automatic wb_io(input logic w_i, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w_i;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_io(1'b1, a, d, rd);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic chk_n(input string nm, input int e, g);
		chk(nm, e, g);
	endtask
	function automatic logic line(int s);
		return (s == 0) ? dstb_n : (s == 1) ? pfstb_n : swp_n;
	endfunction
	function automatic logic [7:0] held(int s);
		return (s == 0) ? pa : (s == 1) ? {7'h00, pf} : 8'h00;
	endfunction
	// Counts the low cycles of a strobe and watches what it qualifies
	task automatic low_width(input int s, input logic [7:0] ev);
		n = 0;
		w = 0;
		ok = 1;
		while (line(s) !== 1'b0 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		while (line(s) === 1'b0 && w < 3000) begin
			if (held(s) !== ev) ok = 0;
			@(negedge clk_i);
			w++;
		end
		repeat (2) @(posedge clk_i);
	endtask
	task automatic trig(input logic [11:0] len);
		@(posedge clk_i);
		low_len <= len;
		go <= 1;
		@(posedge clk_i);
		go <= 0;
		repeat (110) @(posedge clk_i);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		@(negedge clk_i);
		chk("reset outputs", 32'h7, {pa, pb, dir_c, dir_d, dstb_n, pfstb_n,
			swp_n});
		chk("reset levels", 32'h0, {pf, aux_q, pkey, ack});
		$display("test reset done");
		wr(`OFS_BYTE_A, 32'ha5);
		low_width(0, 8'ha5);
		chk_n("data strobe width", 100, w);
		chk("port a before strobe", 1, ok);
		wr(`OFS_BYTE_B, 32'h5a);
		wr(`OFS_BYTE_A, 32'h11);
		low_width(0, 8'ha5);
		chk("port a held", 1, ok);
		chk("ports a b", 16'ha55a, {pa, pb});
		$display("test byte ports done");
		wb_io(1'b0, `OFS_NIB_C, 32'h0, rd);
		chk("c input read", 32'h6, rd);
		wr(`OFS_DIR, 32'h3);
		low_width(0, 8'ha5);
		chk("dir status out", 2'b11, {dir_c, dir_d});
		wr(`OFS_NIB_C, 32'hc);
		low_width(0, 8'ha5);
		chk("c pins", 8'hcf, {c_pin, c_oe});
		wr(`OFS_NIB_D, 32'h5);
		low_width(0, 8'ha5);
		chk("d pins", 8'h5f, {d_pin, d_oe});
		wb_io(1'b0, `OFS_NIB_C, 32'h0, rd);
		chk("c output read", 32'hc, rd);
		wr(`OFS_DIR, 32'h0);
		low_width(0, 8'ha5);
		chk("dir status in", 10'h000, {dir_c, dir_d, c_oe, d_oe});
		wb_io(1'b0, `OFS_NIB_D, 32'h0, rd);
		chk("d input read", 32'h9, rd);
		$display("test nibble ports done");
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_RESULT, i);
			low_width(1, {7'h00, i[0] ~^ i[1]});
			chk_n("pf strobe width", 100, w);
			chk("result level", 1, ok);
		end
		$display("test result done");
		wr(`OFS_SWEEP, 32'h1);
		low_width(2, 8'h00);
		chk_n("sweep done width", 1000, w);
		$display("test sweep done");
		aux_src <= 2'b10;
		trig(12'd99);
		chk("aux short pulse", 2'b00, aux_q);
		trig(12'd100);
		chk("aux loaded", 2'b10, aux_q);
		aux_src <= 2'b01;
		trig(12'd100);
		chk("aux reloaded", 2'b01, aux_q);
		wb_io(1'b0, `OFS_AUX, 32'h0, rd);
		chk("aux readback", 32'h1, rd);
		$display("test trigger done");
		@(posedge clk_i);
		press <= 1;
		n = 0;
		repeat (10) begin
			@(negedge clk_i);
			n += (pkey === 1'b1);
		end
		chk_n("power key pulses", 1, n);
		wb_io(1'b0, `OFS_STATUS, 32'h0, rd);
		chk("power status", 32'h8, rd);
		press <= 0;
		wb_io(1'b0, 8'h3c, 32'h0, rd);
		chk("unmapped read", 32'h0, rd);
		$display("test power and unmapped done");
		stop_test;
	end
	// Tests need about 2500 cycles; give a wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		stop_test;
	end
endmodule
`default_nettype wire
